/* File: design/idr_cfg.svh */
// Timing, pin-map and strap constants for the ISA DMA handshake and refresh block
//-----------------------------------------------------------------------------
// Summary of operation
// - Seven request/grant pairs, channel 4 has none.
// - Request means DMA service or bus-master ownership.
// - Request and grant polarity follow a setting.
// - Requester holds request until its grant appears.
// - Grant marks DMA service or bus ownership.
// - Slave selects itself by grant plus I/O strobe.
// - Master waits for grant before asserting ownership.
// - Terminal count marks end; low when idle.
// - Early variant: strap high means internal DMA mode.
// - Strap low: float aen, count, grants; forward 0000h.
// - Drive refresh only for own refresh, whole cycle.
// - Bus master may start refresh by asserting refresh.
// - Memory uses refresh to steer row address.
// - Memory slaves never drive data during refresh.
// - Device drives memory read in its refresh cycles.
// - Byte-high enable stays negated during refresh.
//-----------------------------------------------------------------------------
`ifndef IDR_CFG_SVH
`define IDR_CFG_SVH

`define IDR_CLK_NS        25
`define IDR_STROBE_NS     125
`define IDR_STROBE_CYC    ((`IDR_STROBE_NS + `IDR_CLK_NS - 1) / `IDR_CLK_NS)
`define IDR_REFRESH_NS    250
`define IDR_REFRESH_CYC   ((`IDR_REFRESH_NS + `IDR_CLK_NS - 1) / `IDR_CLK_NS)
`define IDR_CYC_W         4
`define IDR_CHAN_W        3
`define IDR_CHAN_MASK     8'hef
`define IDR_STRAP_INT     1'b1
`define IDR_ALL_ONES      8'hff
`define IDR_FWD_IO_ADDR   16'h0000

`endif

/* File: design/idr_dev.sv */
// Device end: request arbitration, grants, terminal count, strap and refresh
`include "idr_cfg.svh"

module idr_dev #(
    parameter int  CNT_W         = 16,
    parameter bit  EARLY_VARIANT = 1'b1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    input  wire logic             power_good_i,
    input  wire logic             active_high_i,
    input  wire logic [7:0]       chan_enable_i,
    input  wire logic [7:0]       master_mode_i,
    input  wire logic [CNT_W-1:0] xfer_len_i,
    input  wire logic             dir_read_i,
    input  wire logic             refresh_req_i,
    output logic                  busy_o,
    output logic [2:0]            active_chan_o,
    output logic                  dma_done_o,
    output logic                  ext_refresh_o,
    output logic                  ext_dma_mode_o,
    output logic [15:0]           fwd_io_addr_o,
    idr_link_if.dev               link
);

    initial begin
        if (CNT_W < 1 || CNT_W > 32) begin
            $error("idr_dev: CNT_W out of range");
        end
    end

    //------------------------------------
    // Helpers
    //------------------------------------
    // Lowest pending channel wins; bit 3 flags a hit
    function automatic logic [3:0] pick(input idr_pkg::idr_chan_vec_t req);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    function automatic idr_pkg::idr_chan_vec_t onehot(input logic [2:0] idx);
        return idr_pkg::idr_chan_vec_t'(8'h01 << idx);
    endfunction

    //------------------------------------
    // Pin synchronisers and strap capture
    //------------------------------------
    logic pg_s1;
    logic pg_s2;
    logic pg_d;
    logic tcin_s1;
    logic tcin_s2;
    logic strap_done;
    logic strap_int;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pg_s1   <= 1'b0;
            pg_s2   <= 1'b0;
            pg_d    <= 1'b0;
            tcin_s1 <= 1'b1;
            tcin_s2 <= 1'b1;
        end else if (ce_i) begin
            pg_s1   <= power_good_i;
            pg_s2   <= pg_s1;
            pg_d    <= pg_s2;
            tcin_s1 <= link.terminal_count;
            tcin_s2 <= tcin_s1;
        end
    end

    // Count pin floats until the strap is caught
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            strap_done <= 1'b0;
            strap_int  <= `IDR_STRAP_INT;
        end else if (ce_i && pg_s2 && !pg_d && !strap_done) begin
            strap_done <= 1'b1;
            strap_int  <= EARLY_VARIANT ? tcin_s2 : `IDR_STRAP_INT;
        end
    end

    logic drive_en;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            drive_en       <= 1'b0;
            ext_dma_mode_o <= 1'b0;
            fwd_io_addr_o  <= `IDR_FWD_IO_ADDR;
        end else if (ce_i) begin
            drive_en       <= strap_done && strap_int;
            ext_dma_mode_o <= strap_done && !strap_int;
            fwd_io_addr_o  <= `IDR_FWD_IO_ADDR;
        end
    end

    //------------------------------------
    // Request decode
    //------------------------------------
    idr_pkg::idr_chan_vec_t req_act;
    logic [3:0]             winner;

    always_comb begin
        req_act = (active_high_i ? link.chan_request : ~link.chan_request)
                  & `IDR_CHAN_MASK & chan_enable_i;
        winner  = pick(req_act);
    end

    //------------------------------------
    // Sequencer
    //------------------------------------
    idr_pkg::idr_state_t    state;
    idr_pkg::idr_chan_vec_t grant;
    logic [2:0]             chan;
    logic [CNT_W-1:0]       left;
    logic [`IDR_CYC_W-1:0]  cnt;
    logic                   refresh_pend;
    logic                   refresh_in_d;
    logic                   tc_q;
    logic                   aen_q;
    logic                   memr_q;
    logic                   own_ref_q;
    logic                   io_q;

    // New refresh request wins over the clear on service start
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            refresh_pend <= 1'b0;
        end else if (ce_i) begin
            if (refresh_req_i) begin
                refresh_pend <= 1'b1;
            end else if (state == idr_pkg::st_idle) begin
                refresh_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            refresh_in_d <= 1'b1;
        end else if (ce_i) begin
            refresh_in_d <= link.refresh_n;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state      <= idr_pkg::st_idle;
            grant      <= 8'h00;
            chan       <= 3'h0;
            left       <= '0;
            cnt        <= '0;
            tc_q       <= 1'b0;
            aen_q      <= 1'b0;
            memr_q     <= 1'b0;
            own_ref_q  <= 1'b0;
            io_q       <= 1'b0;
            dma_done_o <= 1'b0;
            ext_refresh_o <= 1'b0;
        end else if (ce_i) begin
            dma_done_o    <= 1'b0;
            ext_refresh_o <= 1'b0;
            unique case (state)
                idr_pkg::st_idle: begin
                    tc_q <= 1'b0;
                    if (refresh_pend) begin
                        state     <= idr_pkg::st_own_refresh;
                        cnt       <= `IDR_CYC_W'(`IDR_REFRESH_CYC - 1);
                        own_ref_q <= 1'b1;
                        memr_q    <= 1'b1;
                    end else if (winner[3] && drive_en) begin
                        chan  <= winner[2:0];
                        grant <= onehot(winner[2:0]);
                        if (master_mode_i[winner[2:0]]) begin
                            state <= idr_pkg::st_master;
                        end else begin
                            state <= idr_pkg::st_dma_addr;
                            left  <= xfer_len_i;
                            aen_q <= 1'b1;
                        end
                    end
                end
                idr_pkg::st_dma_addr: begin
                    state <= idr_pkg::st_dma_strobe;
                    cnt   <= `IDR_CYC_W'(`IDR_STROBE_CYC - 1);
                    io_q  <= 1'b1;
                    tc_q  <= (left == '0);
                end
                idr_pkg::st_dma_strobe: begin
                    if (cnt != '0) begin
                        cnt <= cnt - `IDR_CYC_W'(1);
                    end else begin
                        io_q  <= 1'b0;
                        tc_q  <= 1'b0;
                        state <= idr_pkg::st_dma_recover;
                    end
                end
                idr_pkg::st_dma_recover: begin
                    if (left == '0) begin
                        grant      <= 8'h00;
                        aen_q      <= 1'b0;
                        dma_done_o <= 1'b1;
                        state      <= idr_pkg::st_idle;
                    end else begin
                        left  <= left - CNT_W'(1);
                        state <= idr_pkg::st_dma_addr;
                    end
                end
                idr_pkg::st_master: begin
                    // Owner gives the bus back by dropping its request
                    if (!req_act[chan]) begin
                        grant <= 8'h00;
                        state <= idr_pkg::st_idle;
                    end else if (refresh_in_d && !link.refresh_n) begin
                        state         <= idr_pkg::st_ext_refresh;
                        cnt           <= `IDR_CYC_W'(`IDR_REFRESH_CYC - 1);
                        memr_q        <= 1'b1;
                        ext_refresh_o <= 1'b1;
                    end
                end
                idr_pkg::st_ext_refresh,
                idr_pkg::st_own_refresh: begin
                    if (cnt != '0) begin
                        cnt <= cnt - `IDR_CYC_W'(1);
                    end else begin
                        memr_q    <= 1'b0;
                        own_ref_q <= 1'b0;
                        state     <= (state == idr_pkg::st_ext_refresh) ?
                                     idr_pkg::st_master : idr_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    //------------------------------------
    // Pin drivers, all registered
    //------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            link.dev_grant      <= `IDR_ALL_ONES;
            link.dev_grant_oe_n <= 1'b1;
            link.dev_tc         <= 1'b0;
            link.dev_tc_oe_n    <= 1'b1;
            link.dev_aen        <= 1'b0;
            link.dev_aen_oe_n   <= 1'b1;
        end else if (ce_i) begin
            link.dev_grant      <= active_high_i ? grant : ~grant;
            link.dev_grant_oe_n <= !drive_en;
            link.dev_tc         <= tc_q;
            link.dev_tc_oe_n    <= !drive_en;
            link.dev_aen        <= aen_q;
            link.dev_aen_oe_n   <= !drive_en;
        end
    end

    // Refresh is driven in own refresh only, memory read and byte-high in any refresh, I/O strobes always
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            link.dev_refresh_n    <= 1'b1;
            link.dev_refresh_oe_n <= 1'b1;
            link.dev_memr_n       <= 1'b1;
            link.dev_memr_oe_n    <= 1'b1;
            link.dev_ior_n        <= 1'b1;
            link.dev_iow_n        <= 1'b1;
            link.dev_sbhe_n       <= 1'b1;
            link.dev_sbhe_oe_n    <= 1'b1;
        end else if (ce_i) begin
            link.dev_refresh_n    <= !own_ref_q;
            link.dev_refresh_oe_n <= !own_ref_q;
            link.dev_memr_n       <= !memr_q;
            link.dev_memr_oe_n    <= !memr_q;
            link.dev_ior_n        <= !(io_q && dir_read_i);
            link.dev_iow_n        <= !(io_q && !dir_read_i);
            link.dev_sbhe_n       <= 1'b1;
            link.dev_sbhe_oe_n    <= !memr_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            busy_o        <= 1'b0;
            active_chan_o <= 3'h0;
        end else if (ce_i) begin
            busy_o        <= (state != idr_pkg::st_idle);
            active_chan_o <= chan;
        end
    end

endmodule

/* File: design/idr_host.sv */
// Far end: DMA slaves and 16-bit bus masters facing the handshake device
`include "idr_cfg.svh"

module idr_host (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic       active_high_i,
    input  wire logic [7:0] req_i,
    input  wire logic [7:0] keep_i,
    input  wire logic       master_want_i,
    input  wire logic [2:0] master_chan_i,
    input  wire logic       refresh_start_i,
    input  wire logic       ext_strap_i,
    output logic [7:0]      granted_o,
    output logic [7:0]      selected_o,
    output logic            tc_seen_o,
    output logic            row_refresh_o,
    idr_link_if.host        link
);

    idr_pkg::idr_chan_vec_t pend;
    idr_pkg::idr_chan_vec_t gnt;
    logic                   io_cmd;
    logic                   ref_act;
    logic [`IDR_CYC_W-1:0]  ref_cnt;

    always_comb begin
        gnt    = (active_high_i ? link.chan_grant : ~link.chan_grant) & `IDR_CHAN_MASK;
        io_cmd = !link.dev_ior_n || !link.dev_iow_n;
    end

    // New request wins over the clear by grant
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pend <= 8'h00;
        end else if (ce_i) begin
            pend <= ((pend & ~gnt) | req_i) & `IDR_CHAN_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            link.chan_request <= active_high_i ? 8'h00 : `IDR_ALL_ONES;
            link.host_tc_pd   <= 1'b0;
            granted_o         <= 8'h00;
            selected_o        <= 8'h00;
            tc_seen_o         <= 1'b0;
        end else if (ce_i) begin
            link.chan_request <= active_high_i ? (pend | (gnt & keep_i)) :
                                 ~(pend | (gnt & keep_i));
            link.host_tc_pd   <= ext_strap_i;
            granted_o         <= gnt;
            selected_o        <= io_cmd ? gnt : 8'h00;
            tc_seen_o         <= link.terminal_count && io_cmd;
        end
    end

    // Ownership only once the grant is seen
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            link.host_master_n <= 1'b1;
        end else if (ce_i) begin
            link.host_master_n <= !(master_want_i && gnt[master_chan_i]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ref_act                <= 1'b0;
            ref_cnt                <= '0;
            link.host_refresh_n    <= 1'b1;
            link.host_refresh_oe_n <= 1'b1;
        end else if (ce_i) begin
            if (!ref_act && refresh_start_i && !link.host_master_n) begin
                ref_act                <= 1'b1;
                ref_cnt                <= `IDR_CYC_W'(`IDR_REFRESH_CYC);
                link.host_refresh_n    <= 1'b0;
                link.host_refresh_oe_n <= 1'b0;
            end else if (ref_act && ref_cnt != '0) begin
                ref_cnt <= ref_cnt - `IDR_CYC_W'(1);
            end else begin
                ref_act                <= 1'b0;
                link.host_refresh_n    <= 1'b1;
                link.host_refresh_oe_n <= 1'b1;
            end
        end
    end

    // Data lines left alone in refresh
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            link.host_data_oe_n <= 1'b1;
            row_refresh_o       <= 1'b0;
        end else if (ce_i) begin
            link.host_data_oe_n <= 1'b1;
            row_refresh_o       <= !link.refresh_n && !link.memr_n;
        end
    end

endmodule

/* File: design/idr_link_if.sv */
// Link between the DMA handshake device and its slaves and bus masters
interface idr_link_if;
    logic [7:0] chan_request;
    logic [7:0] dev_grant;
    logic       dev_grant_oe_n;
    logic       dev_tc;
    logic       dev_tc_oe_n;
    logic       host_tc_pd;
    logic       dev_aen;
    logic       dev_aen_oe_n;
    logic       dev_refresh_n;
    logic       dev_refresh_oe_n;
    logic       host_refresh_n;
    logic       host_refresh_oe_n;
    logic       dev_memr_n;
    logic       dev_memr_oe_n;
    logic       dev_ior_n;
    logic       dev_iow_n;
    logic       dev_sbhe_n;
    logic       dev_sbhe_oe_n;
    logic       host_master_n;
    logic       host_data_oe_n;
    // Resolved wire levels, undriven lines pulled high except count, which host_tc_pd pulls low
    logic [7:0] chan_grant;
    logic       terminal_count;
    logic       refresh_n;
    logic       memr_n;

    assign chan_grant     = dev_grant_oe_n ? 8'hff : dev_grant;
    assign terminal_count = !dev_tc_oe_n ? dev_tc : !host_tc_pd;
    assign refresh_n      = !dev_refresh_oe_n ? dev_refresh_n :
                            (!host_refresh_oe_n ? host_refresh_n : 1'b1);
    assign memr_n         = dev_memr_oe_n ? 1'b1 : dev_memr_n;

    modport dev (
        input  chan_request, terminal_count, refresh_n, host_master_n,
        output dev_grant, dev_grant_oe_n, dev_tc, dev_tc_oe_n, dev_aen, dev_aen_oe_n,
        output dev_refresh_n, dev_refresh_oe_n, dev_memr_n, dev_memr_oe_n,
        output dev_ior_n, dev_iow_n, dev_sbhe_n, dev_sbhe_oe_n
    );
    modport host (
        input  chan_grant, terminal_count, refresh_n, memr_n, dev_ior_n, dev_iow_n,
        input  dev_aen,
        output chan_request, host_tc_pd, host_refresh_n, host_refresh_oe_n,
        output host_master_n, host_data_oe_n
    );
endinterface

/* File: design/idr_pkg.sv */
// Shared types of the ISA DMA handshake and refresh block
package idr_pkg;
    typedef logic [7:0] idr_chan_vec_t;

    typedef enum logic [2:0] {
        st_idle,
        st_dma_addr,
        st_dma_strobe,
        st_dma_recover,
        st_master,
        st_ext_refresh,
        st_own_refresh
    } idr_state_t;
endpackage

/* File: dv/idr_link_properties.sv */
// Concurrent checks on the link between the device and host ends
module idr_link_properties (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       active_high_i,
    input  wire logic [7:0] chan_request,
    input  wire logic [7:0] chan_grant,
    input  wire logic       dev_tc,
    input  wire logic       dev_tc_oe_n,
    input  wire logic       dev_ior_n,
    input  wire logic       dev_iow_n,
    input  wire logic       refresh_n,
    input  wire logic       memr_n,
    input  wire logic       dev_refresh_oe_n,
    input  wire logic       dev_sbhe_n,
    input  wire logic       dev_sbhe_oe_n,
    input  wire logic       host_master_n,
    input  wire logic       host_data_oe_n
);
    logic [7:0] req_act;
    logic [7:0] grant_act;
    // Polarity folded out; channel 4 has no pin pair
    assign req_act   = (active_high_i ? chan_request : ~chan_request) & 8'hef;
    assign grant_act = (active_high_i ? chan_grant : ~chan_grant) & 8'hef;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    //------------------------------------
    // Sequences
    //------------------------------------
    sequence tc_burst;
        dev_tc [*5] ##1 !dev_tc;
    endsequence
    sequence own_refresh;
        !refresh_n [*8] ##[1:4] refresh_n;
    endsequence

    //------------------------------------
    // Properties
    //------------------------------------
    chk_grant_has_cause: assert property ($rose(|grant_act) |-> |(grant_act & $past(req_act, 2)))
        else $error("grant without request");
    chk_request_held: assert property (($past(req_act) & ~req_act & ~grant_act) == 8'h00)
        else $error("request dropped early");
    chk_tc_idle_low: assert property ((dev_ior_n && dev_iow_n && !dev_tc_oe_n) |-> !dev_tc)
        else $error("count high off strobe");
    chk_tc_pulse_len: assert property (($rose(dev_tc) && !dev_tc_oe_n) |-> tc_burst)
        else $error("count pulse length");
    chk_refresh_own_len: assert property (($fell(refresh_n) && !dev_refresh_oe_n) |-> own_refresh)
        else $error("own refresh length wrong");
    chk_refresh_memr: assert property ($fell(refresh_n) |-> ##[0:2] !memr_n)
        else $error("no read in refresh");
    chk_sbhe_negated: assert property (!refresh_n |-> (dev_sbhe_oe_n || dev_sbhe_n))
        else $error("byte high in refresh");
    chk_master_after_grant: assert property ($fell(host_master_n) |-> |grant_act)
        else $error("master before grant");
    chk_data_float: assert property (!refresh_n |-> host_data_oe_n)
        else $error("data driven in refresh");
endmodule

/* File: dv/tb_isa_dma_handshake_refresh.sv */
// Self-checking bench joining the device and host ends over one link
`include "idr_cfg.svh"
module tb_isa_dma_handshake_refresh;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0, resetn_i = 1'b0, power_good_i = 1'b0, active_high_i = 1'b1;
    logic        dir_read_i = 1'b1, refresh_req_i = 1'b0, master_want_i = 1'b0;
    logic        refresh_start_i = 1'b0, ext_strap_i = 1'b0;
    logic        busy_o, dma_done_o, ext_refresh_o, ext_dma_mode_o, tc_seen_o, row_refresh_o;
    logic [2:0]  active_chan_o;
    logic [7:0]  chan_enable_i = 8'h6f, master_mode_i = 8'h02, req_i = 8'h00, keep_i = 8'h00;
    logic [7:0]  granted_o, selected_o, g;
    logic [15:0] xfer_len_i = 16'h0000, fwd_io_addr_o;
    int          err_total = 0, num_checks = 0;
    int          n_sel, n_tc, n_done, n_row, n_rfl, n_ext;

    idr_link_if link_if ();
    always #12.5 clk_sys_i = ~clk_sys_i;

    idr_dev idr_dev_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1), .power_good_i(power_good_i),
        .active_high_i(active_high_i), .chan_enable_i(chan_enable_i),
        .master_mode_i(master_mode_i), .xfer_len_i(xfer_len_i), .dir_read_i(dir_read_i),
        .refresh_req_i(refresh_req_i), .busy_o(busy_o), .active_chan_o(active_chan_o),
        .dma_done_o(dma_done_o), .ext_refresh_o(ext_refresh_o),
        .ext_dma_mode_o(ext_dma_mode_o), .fwd_io_addr_o(fwd_io_addr_o), .link(link_if));
    idr_host idr_host_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1), .active_high_i(active_high_i),
        .req_i(req_i), .keep_i(keep_i), .master_want_i(master_want_i), .master_chan_i(3'h1),
        .refresh_start_i(refresh_start_i), .ext_strap_i(ext_strap_i), .granted_o(granted_o),
        .selected_o(selected_o), .tc_seen_o(tc_seen_o), .row_refresh_o(row_refresh_o),
        .link(link_if));
    idr_link_properties idr_link_properties_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .active_high_i(active_high_i),
        .chan_request(link_if.chan_request), .chan_grant(link_if.chan_grant),
        .dev_tc(link_if.dev_tc), .dev_tc_oe_n(link_if.dev_tc_oe_n),
        .dev_ior_n(link_if.dev_ior_n), .dev_iow_n(link_if.dev_iow_n),
        .refresh_n(link_if.refresh_n), .memr_n(link_if.memr_n),
        .dev_refresh_oe_n(link_if.dev_refresh_oe_n), .dev_sbhe_n(link_if.dev_sbhe_n),
        .dev_sbhe_oe_n(link_if.dev_sbhe_oe_n), .host_master_n(link_if.host_master_n),
        .host_data_oe_n(link_if.host_data_oe_n));

    //------------------------------------
    // Shared tasks
    //------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input logic strap, input logic pol);
        @(negedge clk_sys_i);
        resetn_i = 1'b0;
        power_good_i = 1'b0;
        ext_strap_i = strap;
        active_high_i = pol;
        repeat (16) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        power_good_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
    endtask
    // Requests are sticky in the host, so a one-cycle pulse suffices
    task automatic pulse_req(input logic [7:0] m);
        req_i = m;
        @(negedge clk_sys_i);
        req_i = 8'h00;
    endtask
    task automatic wait_grant();
        int n = 0;
        while ((granted_o === 8'h00 || granted_o === g) && n < 40) begin
            @(negedge clk_sys_i);
            n++;
        end
        g = granted_o;
    endtask
    task automatic watch(input int cycles);
        logic ps = 1'b0, pt = 1'b0;
        {n_sel, n_tc, n_done, n_row, n_rfl, n_ext} = '0;
        repeat (cycles) begin
            @(negedge clk_sys_i);
            n_sel += int'((|selected_o) && !ps);
            n_tc += int'(tc_seen_o && !pt);
            n_done += int'(dma_done_o === 1'b1);
            n_row += int'(row_refresh_o === 1'b1);
            n_rfl += int'(link_if.refresh_n === 1'b0);
            n_ext += int'(ext_refresh_o === 1'b1);
            ps = |selected_o;
            pt = tc_seen_o;
        end
    endtask

    //------------------------------------
    // Scenarios
    //------------------------------------
    task automatic t_dma_basic();
        chk("ext_mode", 16'h0000, ext_dma_mode_o);
        pulse_req(8'h01);
        wait_grant();
        chk("grant", 16'h0001, g);
        watch(30);
        chk("selects", 16'h0001, n_sel[15:0]);
        chk("tc_pulses", 16'h0001, n_tc[15:0]);
        chk("done", 16'h0001, n_done[15:0]);
        chk("chan", 16'h0000, active_chan_o);
        chk("tc_idle", 16'h0000, link_if.terminal_count);
        chk("grant_idle", 16'h0000, link_if.chan_grant & 8'hef);
        $display("test dma_basic done");
    endtask
    task automatic t_priority();
        pulse_req(8'hf0);
        wait_grant();
        chk("first_grant", 16'h0020, g);
        wait_grant();
        chk("second_grant", 16'h0040, g);
        watch(40);
        chk("disabled", 16'h0000, granted_o);
        chk("busy", 16'h0000, busy_o);
        $display("test priority done");
    endtask
    task automatic t_own_refresh();
        refresh_req_i = 1'b1;
        @(negedge clk_sys_i);
        refresh_req_i = 1'b0;
        watch(30);
        chk("refresh_len", 16'(`IDR_REFRESH_CYC), n_rfl[15:0]);
        chk("row_refresh", 16'h0001, 16'(n_row != 0));
        chk("refresh_end", 16'h0001, link_if.refresh_n);
        $display("test own_refresh done");
    endtask
    task automatic t_master();
        master_want_i = 1'b1;
        keep_i = 8'h02;
        pulse_req(8'h02);
        wait_grant();
        chk("master_grant", 16'h0002, g);
        repeat (3) @(negedge clk_sys_i);
        chk("master_own", 16'h0000, link_if.host_master_n);
        refresh_start_i = 1'b1;
        @(negedge clk_sys_i);
        refresh_start_i = 1'b0;
        watch(20);
        chk("ext_refresh", 16'h0001, n_ext[15:0]);
        chk("row_refresh", 16'h0001, 16'(n_row != 0));
        master_want_i = 1'b0;
        keep_i = 8'h00;
        watch(20);
        chk("master_release", 16'h0000, granted_o);
        $display("test master done");
    endtask
    task automatic t_polarity_low();
        do_reset(1'b0, 1'b0);
        dir_read_i = 1'b0;
        xfer_len_i = 16'h0002;
        pulse_req(8'h08);
        wait_grant();
        chk("low_grant", 16'h0008, g);
        watch(80);
        chk("transfers", 16'h0003, n_sel[15:0]);
        chk("tc_final", 16'h0001, n_tc[15:0]);
        chk("done", 16'h0001, n_done[15:0]);
        chk("grant_idle", 16'h00ef, link_if.chan_grant & 8'hef);
        dir_read_i = 1'b1;
        xfer_len_i = 16'h0000;
        $display("test polarity_low done");
    endtask
    task automatic t_ext_mode();
        do_reset(1'b1, 1'b1);
        chk("ext_mode", 16'h0001, ext_dma_mode_o);
        chk("fwd_addr", 16'h0000, fwd_io_addr_o);
        pulse_req(8'h01);
        watch(20);
        chk("grant_float", 16'h00ff, link_if.chan_grant);
        chk("tc_float", 16'h0000, link_if.terminal_count);
        chk("no_service", 16'h0000, n_sel[15:0]);
        chk("busy", 16'h0000, busy_o);
        $display("test ext_mode done");
    endtask

    initial begin
        do_reset(1'b0, 1'b1);
        t_dma_basic();
        t_priority();
        t_own_refresh();
        t_master();
        t_polarity_low();
        t_ext_mode();
        end_sim();
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        err_total++;
        end_sim();
    end
endmodule
